/* include/pixel_sync_pkg.sv */
package pixel_sync_pkg;

  // ==========================================
  // Widths
  localparam int NUM_CH = 4;
  localparam int WORD_W = 10;
  localparam int DATA_W = NUM_CH * WORD_W;
  localparam int XFER_W = DATA_W + 3 * WORD_W + 5;
  localparam int SPI_FRAME = 26;
  localparam int SPI_CMD = 10;

  // ==========================================
  // Register offsets on the serial control port
  localparam logic [8:0] A_DARK_CAL = 9'h080;
  localparam logic [8:0] A_GEN_CFG = 9'h081;
  localparam logic [8:0] A_IDLE = 9'h082;
  localparam logic [8:0] A_MARK_FR = 9'h083;
  localparam logic [8:0] A_MARK_DARK = 9'h084;
  localparam logic [8:0] A_MARK_IMG = 9'h085;
  localparam logic [8:0] A_MARK_CRC = 9'h086;
  localparam logic [8:0] A_MARK_TRN = 9'h087;
  localparam logic [8:0] A_DARK_ERR = 9'h089;

  // ==========================================
  // Reset values
  localparam logic [15:0] RST_DARK_CAL = 16'h4008;
  localparam logic [15:0] RST_GEN_CFG = 16'hC001;
  localparam logic [15:0] RST_IDLE = 16'h03A6;
  localparam logic [15:0] RST_MARK_FR = 16'h002A;
  localparam logic [15:0] RST_MARK_DARK = 16'h0015;
  localparam logic [15:0] RST_MARK_IMG = 16'h0035;
  localparam logic [15:0] RST_MARK_CRC = 16'h0059;
  localparam logic [15:0] RST_MARK_TRN = 16'h03A6;

  // ==========================================
  // Field positions
  localparam int F_TGT_MSB = 7;
  localparam int F_NSMP_LSB = 8;
  localparam int F_NSMP_MSB = 10;
  localparam int F_ADCX_LSB = 11;
  localparam int F_ADCX_MSB = 14;
  localparam int F_SEED = 15;
  localparam int F_AUTO = 0;
  localparam int F_MAN_LSB = 1;
  localparam int F_MAN_MSB = 9;
  localparam int F_SUB = 10;
  localparam int F_NARROW = 13;
  localparam int F_FR_DARK = 14;
  localparam int F_ROW_DARK = 15;
  localparam int F_CODE_MSB = 9;
  localparam int F_FRLSB_MSB = 6;
  localparam int NARROW_DELAY = 4;
  // Core cycles the link side is held in reset; spans several slow link clocks
  localparam logic [6:0] LINK_RST_HOLD = 7'h64;

  // Kind of each word offered by the pixel source
  typedef enum logic [2:0] {
    K_FRAME_START, K_FRAME_END, K_ROW_START, K_ROW_END, K_DARK, K_IMAGE
  } pix_kind_t;

endpackage

/* hw/two_entry_buffer.sv */
`timescale 1ns/1ns
`default_nettype none
module two_entry_buffer #(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  logic [WIDTH-1:0] slot_q [2];
  logic wrPtr_q;
  logic rdPtr_q;
  logic [1:0] count_q;
  logic push;
  logic pop;

  // ==========================================
  // Handshakes
  assign inReady = (count_q != 2'h2);
  assign outValid = (count_q != 2'h0);
  assign outData = slot_q[rdPtr_q];
  assign push = inValid && inReady;
  assign pop = outValid && outReady;

  // Storage, written only on a push
  always_ff @(posedge core_clk) begin
    if (push) begin
      slot_q[wrPtr_q] <= inData;
    end
  end

  // Pointers and fill level
  always_ff @(posedge core_clk) begin
    if (reset) begin
      wrPtr_q <= 1'b0;
      rdPtr_q <= 1'b0;
      count_q <= 2'h0;
    end else begin
      if (push) wrPtr_q <= ~wrPtr_q;
      if (pop) rdPtr_q <= ~rdPtr_q;
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

endmodule
`default_nettype wire

/* hw/pixel_sync_framer.sv */
`timescale 1ns/1ns
`default_nettype none
module pixel_sync_framer
  import pixel_sync_pkg::*;
(
  // Core clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Serial control port
  input wire logic spiSclk,
  input wire logic spiCsN,
  input wire logic spiMosi,
  output logic spiMiso,
  // Pixel source
  input wire logic pixValid,
  output logic pixReady,
  input wire pix_kind_t pixKind,
  input wire logic [DATA_W-1:0] pixData,
  // Serial link side
  input wire logic linkClk,
  output logic [DATA_W-1:0] linkData,
  output logic [WORD_W-1:0] linkSync,
  output logic frameActiveFlag,
  output logic rowActiveFlag
);

  typedef enum logic {ST_PASS, ST_CSUM} framer_state_t;

  // ==========================================
  // Control port synchronisers
  logic [2:0] sclkSr_q;
  logic [1:0] csSr_q;
  logic [1:0] mosiSr_q;
  logic sclkRise;
  logic sclkFall;
  logic csActive;

  // Pins are asynchronous; edges seen only after two flops
  always_ff @(posedge core_clk) begin
    if (reset) begin
      sclkSr_q <= 3'h0;
      csSr_q <= 2'h3;
      mosiSr_q <= 2'h0;
    end else begin
      sclkSr_q <= {sclkSr_q[1:0], spiSclk};
      csSr_q <= {csSr_q[0], spiCsN};
      mosiSr_q <= {mosiSr_q[0], spiMosi};
    end
  end

  assign sclkRise = sclkSr_q[1] && !sclkSr_q[2];
  assign sclkFall = !sclkSr_q[1] && sclkSr_q[2];
  assign csActive = !csSr_q[1];

  // ==========================================
  // Control port frame: address, write bit, data
  logic [SPI_FRAME-2:0] spiShift_q;
  logic [4:0] bitCnt_q;
  logic [15:0] rdShift_q;
  logic [SPI_FRAME-1:0] spiFull;
  logic wrStrobe;
  logic [8:0] wrAddr;
  logic [15:0] wrData;
  logic [NUM_CH-1:0] darkErr;

  assign spiFull = {spiShift_q, mosiSr_q[1]};
  assign wrStrobe = csActive && sclkRise && (bitCnt_q == 5'(SPI_FRAME - 1))
                    && spiFull[16];
  assign wrAddr = spiFull[25:17];
  assign wrData = spiFull[15:0];

  // Configuration registers
  logic [15:0] darkCal_q;
  logic [15:0] genCfg_q;
  logic [15:0] idle_q;
  logic [15:0] markFr_q;
  logic [15:0] markDark_q;
  logic [15:0] markImg_q;
  logic [15:0] markCrc_q;
  logic [15:0] markTrn_q;

  // Read mux; unmapped offsets read as zero
  function automatic logic [15:0] readReg(input logic [8:0] a);
    case (a)
      A_DARK_CAL: readReg = darkCal_q;
      A_GEN_CFG: readReg = genCfg_q;
      A_IDLE: readReg = idle_q;
      A_MARK_FR: readReg = markFr_q;
      A_MARK_DARK: readReg = markDark_q;
      A_MARK_IMG: readReg = markImg_q;
      A_MARK_CRC: readReg = markCrc_q;
      A_MARK_TRN: readReg = markTrn_q;
      A_DARK_ERR: readReg = {12'h000, darkErr};
      default: readReg = 16'h0000;
    endcase
  endfunction

  // Shift in on rising clock, read data out on falling clock
  always_ff @(posedge core_clk) begin
    if (reset || !csActive) begin
      spiShift_q <= '0;
      bitCnt_q <= 5'h00;
      rdShift_q <= 16'h0000;
      spiMiso <= 1'b0;
    end else begin
      if (sclkRise) begin
        spiShift_q <= spiFull[SPI_FRAME-2:0];
        bitCnt_q <= bitCnt_q + 5'h01;
        // Read data is latched once the command is complete
        if (bitCnt_q == 5'(SPI_CMD - 1) && !spiFull[0]) begin
          rdShift_q <= readReg(spiFull[9:1]);
        end
      end
      if (sclkFall && bitCnt_q >= 5'(SPI_CMD)) begin
        spiMiso <= rdShift_q[15];
        rdShift_q <= {rdShift_q[14:0], 1'b0};
      end
    end
  end

  // Register writes; unmapped writes are dropped
  always_ff @(posedge core_clk) begin
    if (reset) begin
      darkCal_q <= RST_DARK_CAL;
      genCfg_q <= RST_GEN_CFG;
      idle_q <= RST_IDLE;
      markFr_q <= RST_MARK_FR;
      markDark_q <= RST_MARK_DARK;
      markImg_q <= RST_MARK_IMG;
      markCrc_q <= RST_MARK_CRC;
      markTrn_q <= RST_MARK_TRN;
    end else if (wrStrobe) begin
      case (wrAddr)
        A_DARK_CAL: darkCal_q <= wrData;
        A_GEN_CFG: genCfg_q <= wrData;
        A_IDLE: idle_q <= wrData;
        A_MARK_FR: markFr_q <= wrData;
        A_MARK_DARK: markDark_q <= wrData;
        A_MARK_IMG: markImg_q <= wrData;
        A_MARK_CRC: markCrc_q <= wrData;
        A_MARK_TRN: markTrn_q <= wrData;
        default: ;
      endcase
    end
  end

  // ==========================================
  // Configuration fields
  logic [7:0] tgtLevel;
  logic [2:0] smpExp;
  logic [3:0] adcExp;
  logic [8:0] manVal;
  logic [7:0] nSamp;
  logic signed [17:0] removeVal;

  assign tgtLevel = darkCal_q[F_TGT_MSB:0];
  assign smpExp = darkCal_q[F_NSMP_MSB:F_NSMP_LSB];
  assign adcExp = darkCal_q[F_ADCX_MSB:F_ADCX_LSB];
  assign manVal = genCfg_q[F_MAN_MSB:F_MAN_LSB];
  assign nSamp = 8'h01 << smpExp;

  // ==========================================
  // Framer state
  framer_state_t state_q;
  logic inFrame_q;
  logic darkRow_q;
  logic accept;
  logic bufInReady;
  logic bufInValid;
  logic isPixel;
  logic [WORD_W-1:0] syncWord;
  logic [DATA_W-1:0] wordData;
  logic [DATA_W-1:0] corrData;
  logic [DATA_W-1:0] csumData;
  logic frameAct;
  logic rowAct;

  assign pixReady = (state_q == ST_PASS) && bufInReady;
  assign accept = pixValid && pixReady;
  assign isPixel = (pixKind == K_DARK) || (pixKind == K_IMAGE);
  assign bufInValid = (state_q == ST_CSUM) || pixValid;

  // Row end costs two words: the end marker, then the checksum
  always_ff @(posedge core_clk) begin
    if (reset) begin
      state_q <= ST_PASS;
    end else begin
      case (state_q)
        ST_PASS: if (accept && pixKind == K_ROW_END) state_q <= ST_CSUM;
        ST_CSUM: if (bufInReady) state_q <= ST_PASS;
        default: state_q <= ST_PASS;
      endcase
    end
  end

  // Frame and dark-row tracking
  always_ff @(posedge core_clk) begin
    if (reset) begin
      inFrame_q <= 1'b0;
      darkRow_q <= 1'b0;
    end else if (accept) begin
      if (pixKind == K_FRAME_START) inFrame_q <= 1'b1;
      if (pixKind == K_FRAME_END) inFrame_q <= 1'b0;
      if (pixKind == K_ROW_START) darkRow_q <= 1'b0;
      if (pixKind == K_DARK) darkRow_q <= 1'b1;
    end
  end

  // ==========================================
  // Offset removed from each raw word
  always_comb begin
    removeVal = 18'sd1 <<< adcExp;
    if (genCfg_q[F_SUB]) begin
      removeVal = removeVal + $signed({9'h000, manVal});
    end else begin
      removeVal = removeVal - $signed({9'h000, manVal});
    end
  end

  // Per-channel correction, calibration and checksum
  for (genvar ch = 0; ch < NUM_CH; ch++) begin : g_ch
    logic [WORD_W-1:0] raw;
    logic [WORD_W-1:0] level_q;
    logic [16:0] acc_q;
    logic [16:0] accNext;
    logic [7:0] cnt_q;
    logic err_q;
    logic [WORD_W-1:0] csum_q;
    logic signed [17:0] rem;
    logic signed [17:0] val;
    logic [WORD_W-1:0] corr;

    assign raw = pixData[ch*WORD_W +: WORD_W];
    assign accNext = acc_q + {7'h00, raw};
    assign rem = genCfg_q[F_AUTO] ?
                 $signed({8'h00, level_q}) - $signed({10'h000, tgtLevel}) : removeVal;
    assign val = $signed({8'h00, raw}) - rem;
    // Clamp keeps a big offset from wrapping bright pixels to black
    assign corr = (val < 0) ? 10'h000 : (val > 18'sd1023) ? 10'h3FF : val[9:0];
    // Narrow words carry the upper eight bits
    assign corrData[ch*WORD_W +: WORD_W] = genCfg_q[F_NARROW] ?
                                           {2'h0, corr[9:2]} : corr;
    assign csumData[ch*WORD_W +: WORD_W] = csum_q;
    assign darkErr[ch] = err_q;

    // Dark averaging restarts each frame
    always_ff @(posedge core_clk) begin
      if (reset) begin
        acc_q <= 17'h00000;
        cnt_q <= 8'h00;
        level_q <= 10'h000;
        err_q <= 1'b0;
      end else if (accept) begin
        if (pixKind == K_FRAME_START) begin
          acc_q <= 17'h00000;
          cnt_q <= 8'h00;
        end
        if (pixKind == K_DARK && cnt_q < nSamp) begin
          acc_q <= accNext;
          cnt_q <= cnt_q + 8'h01;
          if (cnt_q + 8'h01 == nSamp) level_q <= 10'(accNext >> smpExp);
        end
        if (pixKind == K_FRAME_END) err_q <= genCfg_q[F_AUTO] && (cnt_q < nSamp);
      end
    end

    // Rotate-and-xor checksum over the words actually sent
    always_ff @(posedge core_clk) begin
      if (reset) begin
        csum_q <= 10'h000;
      end else if (accept) begin
        if (pixKind == K_ROW_START) csum_q <= {WORD_W{darkCal_q[F_SEED]}};
        if (isPixel) begin
          csum_q <= {csum_q[8:0], csum_q[9]} ^ corrData[ch*WORD_W +: WORD_W];
        end
      end
    end
  end

  // ==========================================
  // Word composition
  always_comb begin
    syncWord = markTrn_q[F_CODE_MSB:0];
    wordData = {NUM_CH{idle_q[WORD_W-1:0]}};
    rowAct = 1'b0;
    frameAct = inFrame_q && !(darkRow_q && !genCfg_q[F_FR_DARK]);
    if (state_q == ST_CSUM) begin
      syncWord = markCrc_q[F_CODE_MSB:0];
      wordData = csumData;
    end else begin
      case (pixKind)
        K_FRAME_START: begin
          syncWord = {3'b110, markFr_q[F_FRLSB_MSB:0]};
          // Flag rises with the start marker itself
          frameAct = 1'b1;
        end
        K_FRAME_END: begin
          syncWord = {3'b101, markFr_q[F_FRLSB_MSB:0]};
          // Link side holds the flag in gaps, so it must fall here
          frameAct = 1'b0;
        end
        K_ROW_START: syncWord = {3'b010, markFr_q[F_FRLSB_MSB:0]};
        K_ROW_END: syncWord = {3'b001, markFr_q[F_FRLSB_MSB:0]};
        K_DARK: begin
          syncWord = markDark_q[F_CODE_MSB:0];
          wordData = corrData;
          rowAct = genCfg_q[F_ROW_DARK];
          frameAct = inFrame_q && genCfg_q[F_FR_DARK];
        end
        K_IMAGE: begin
          syncWord = markImg_q[F_CODE_MSB:0];
          wordData = corrData;
          rowAct = 1'b1;
        end
        default: ;
      endcase
    end
  end

  // ==========================================
  // Buffer ahead of the crossing
  logic bufOutValid;
  logic bufOutReady;
  logic [DATA_W+WORD_W+1:0] bufOutData;

  two_entry_buffer #(.WIDTH(DATA_W + WORD_W + 2)) u_buf (
    .core_clk(core_clk),
    .reset(reset),
    .inValid(bufInValid),
    .inReady(bufInReady),
    .inData({frameAct, rowAct, syncWord, wordData}),
    .outValid(bufOutValid),
    .outReady(bufOutReady),
    .outData(bufOutData)
  );

  // ==========================================
  // Toggle handshake into the link domain
  logic txReq_q;
  logic [1:0] ackSr_q;
  logic [XFER_W-1:0] txHold_q;
  logic linkAck_q;
  logic txBusy;
  logic [6:0] rstCnt_q;
  logic linkRstReq_q;

  // A short core reset can fall between two slow link edges; stretch it
  always_ff @(posedge core_clk) begin
    if (reset) begin
      rstCnt_q <= 7'h00;
      linkRstReq_q <= 1'b1;
    end else if (linkRstReq_q) begin
      rstCnt_q <= rstCnt_q + 7'h01;
      if (rstCnt_q == LINK_RST_HOLD) linkRstReq_q <= 1'b0;
    end
  end

  // Busy until the acknowledge toggle has caught up
  assign txBusy = (txReq_q != ackSr_q[1]);
  // Nothing leaves the buffer while the link side is still held in reset
  assign bufOutReady = !txBusy && !linkRstReq_q;

  // Empty slots still send config so the link side stays current
  always_ff @(posedge core_clk) begin
    if (reset || linkRstReq_q) begin
      txReq_q <= 1'b0;
      ackSr_q <= 2'h0;
      txHold_q <= '0;
    end else begin
      ackSr_q <= {ackSr_q[0], linkAck_q};
      if (!txBusy) begin
        txReq_q <= ~txReq_q;
        txHold_q <= {genCfg_q[F_NARROW], markTrn_q[F_CODE_MSB:0],
                     idle_q[WORD_W-1:0], !bufOutValid, 1'b0, bufOutData};
      end
    end
  end

  // ==========================================
  // Link domain
  logic [1:0] linkRstSr_q;
  logic linkRst;
  logic [2:0] reqSr_q;
  logic newWord;
  logic [WORD_W-1:0] lnkIdle_q;
  logic [WORD_W-1:0] lnkTag_q;
  logic lnkNarrow_q;
  logic [WORD_W-1:0] syncDly_q [NARROW_DELAY];
  logic [WORD_W-1:0] syncNow;
  logic xIdle;

  assign linkRst = linkRstSr_q[1];
  assign newWord = reqSr_q[1] ^ reqSr_q[2];
  assign xIdle = txHold_q[DATA_W+WORD_W+3];

  // Reset and request toggle brought over by two flops
  always_ff @(posedge linkClk) begin
    linkRstSr_q <= {linkRstSr_q[0], linkRstReq_q};
    reqSr_q <= {reqSr_q[1:0], txReq_q};
  end

  // Held word is stable while the request toggle is unanswered
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      linkAck_q <= 1'b0;
      lnkIdle_q <= RST_IDLE[WORD_W-1:0];
      lnkTag_q <= RST_MARK_TRN[WORD_W-1:0];
      lnkNarrow_q <= 1'b0;
    end else if (newWord) begin
      linkAck_q <= reqSr_q[1];
      lnkIdle_q <= txHold_q[DATA_W+WORD_W+4 +: WORD_W];
      lnkTag_q <= txHold_q[DATA_W+2*WORD_W+4 +: WORD_W];
      lnkNarrow_q <= txHold_q[XFER_W-1];
    end
  end

  assign syncNow = (newWord && !xIdle) ? txHold_q[DATA_W +: WORD_W] : lnkTag_q;

  // sync codes lag four words in narrow mode
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      for (int i = 0; i < NARROW_DELAY; i++) syncDly_q[i] <= RST_MARK_TRN[WORD_W-1:0];
    end else begin
      syncDly_q[0] <= syncNow;
      for (int i = 1; i < NARROW_DELAY; i++) syncDly_q[i] <= syncDly_q[i-1];
    end
  end

  // Link outputs, all registered
  always_ff @(posedge linkClk) begin
    if (linkRst) begin
      linkData <= {NUM_CH{RST_IDLE[WORD_W-1:0]}};
      linkSync <= RST_MARK_TRN[WORD_W-1:0];
      frameActiveFlag <= 1'b0;
      rowActiveFlag <= 1'b0;
    end else begin
      linkSync <= lnkNarrow_q ? syncDly_q[NARROW_DELAY-1] : syncNow;
      if (newWord && !xIdle) begin
        linkData <= txHold_q[DATA_W-1:0];
        rowActiveFlag <= txHold_q[DATA_W+WORD_W];
        frameActiveFlag <= txHold_q[DATA_W+WORD_W+1];
      end else begin
        // idle word on every data channel
        linkData <= {NUM_CH{lnkIdle_q}};
        rowActiveFlag <= 1'b0;
      end
    end
  end

endmodule
`default_nettype wire

/* verif/pixel_sync_framer_properties.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Port checks of the framer
module pixel_sync_framer_properties
  import pixel_sync_pkg::*;
(
  // Clocks and reset
  input wire logic core_clk,
  input wire logic reset,
  input wire logic linkClk,
  // Serial control port
  input wire logic spiSclk,
  input wire logic spiCsN,
  input wire logic spiMiso,
  // Pixel source
  input wire logic pixValid,
  input wire logic pixReady,
  input wire pix_kind_t pixKind,
  // Link side
  input wire logic [DATA_W-1:0] linkData,
  input wire logic [WORD_W-1:0] linkSync,
  input wire logic frameActiveFlag,
  input wire logic rowActiveFlag
);
  a_miso_idle_deselect: assert property (@(posedge core_clk) disable iff (reset)
    spiCsN [*4] |-> !spiMiso) else $error("read data not cleared when deselected");
  a_miso_hold_high: assert property (@(posedge core_clk) disable iff (reset)
    (!spiCsN && spiSclk) [*6] |-> $stable(spiMiso)) else $error("read data moved");
  a_ready_after_reset: assert property (@(posedge core_clk) disable iff (reset)
    $fell(reset) |-> ##[0:3] pixReady) else $error("pixel input not ready after reset");
  a_ready_csum_slot: assert property (@(posedge core_clk) disable iff (reset)
    pixValid && pixReady && pixKind == K_ROW_END |=> !pixReady) else $error("no checksum slot");
  a_link_word_edge: assert property (@(posedge core_clk) disable iff (reset)
    $changed(linkData) |-> linkClk && !$past(linkClk)) else $error("link word off its clock");
  // Link side leaves its stretched reset showing only idle
  a_link_reset_idle: assert property (@(posedge core_clk) disable iff (reset)
    $fell(reset) |-> ##150 (linkSync == 10'h3A6 && linkData == {NUM_CH{10'h3A6}}
    && !frameActiveFlag && !rowActiveFlag)) else $error("link not idle after reset");
  a_csum_after_end: assert property (@(posedge linkClk) disable iff (reset)
    linkSync[9:7] == 3'b001 |-> ##[1:3] linkSync == 10'h059) else $error("no checksum tag");
  a_frame_on_start: assert property (@(posedge linkClk) disable iff (reset)
    linkSync[9:7] == 3'b110 |-> ##[0:1] frameActiveFlag) else $error("frame flag not set");
  a_frame_off_end: assert property (@(posedge linkClk) disable iff (reset)
    linkSync[9:7] == 3'b101 |=> !frameActiveFlag [*2]) else $error("frame flag after end");
endmodule
bind pixel_sync_framer pixel_sync_framer_properties i_props (.core_clk, .reset, .linkClk,
  .spiSclk, .spiCsN, .spiMiso, .pixValid, .pixReady, .pixKind, .linkData, .linkSync,
  .frameActiveFlag, .rowActiveFlag);
`default_nettype wire

/* verif/image_receiver_model.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Receiver at the far end of the link
module image_receiver_model
  import pixel_sync_pkg::*;
(
  // Link clock and reset
  input wire logic linkClk,
  input wire logic reset,
  // Link words
  input wire logic [DATA_W-1:0] linkData,
  input wire logic [WORD_W-1:0] linkSync,
  input wire logic frameActiveFlag,
  input wire logic rowActiveFlag,
  // Codes to decode against
  input wire logic [WORD_W-1:0] idleWord,
  input wire logic [WORD_W-1:0] imgCode,
  input wire logic [WORD_W-1:0] darkCode,
  input wire logic [WORD_W-1:0] crcCode,
  input wire logic [DATA_W-1:0] probe,
  // Decoded results
  output logic aligned,
  output logic [DATA_W-1:0] lastImg,
  output logic [DATA_W-1:0] lastCsum,
  output logic [1:0] darkFlags,
  output logic [WORD_W-1:0] lastMark,
  output logic [7:0] markCount,
  output logic [7:0] probeAt,
  output logic [7:0] imgAt
);
  logic [7:0] wordIdx;
  // word alignment
  // Lock only on idle seen on every lane, so one slipped lane cannot fool it
  // Bench reset is shorter than a link period, so the model clears at once
  always_ff @(posedge linkClk or posedge reset) begin
    if (reset) aligned <= 1'b0;
    else if (linkData == {NUM_CH{idleWord}}) aligned <= 1'b1;
  end
  // Word counter to measure sync against data position
  always_ff @(posedge linkClk or posedge reset) begin
    if (reset) wordIdx <= 8'h00;
    else wordIdx <= wordIdx + 8'h01;
  end
  always_ff @(posedge linkClk or posedge reset) begin
    if (reset) begin
      markCount <= 8'h00;
    end else if (aligned) begin
      if (linkSync == imgCode) lastImg <= linkData;
      if (linkSync == imgCode) imgAt <= wordIdx;
      if (linkData == probe) probeAt <= wordIdx;
      if (linkSync == crcCode) lastCsum <= linkData;
      if (linkSync == darkCode) darkFlags <= {frameActiveFlag, rowActiveFlag};
      if (linkSync[9:7] inside {3'b110, 3'b101, 3'b010, 3'b001}) begin
        lastMark <= linkSync;
        markCount <= markCount + 8'h01;
      end
    end
  end
endmodule
`default_nettype wire

/* verif/tb.sv */
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Bench for the pixel sync framer
module tb
  import pixel_sync_pkg::*;
;
  logic core_clk, reset, linkClk, spiSclk, spiCsN, spiMosi, spiMiso, pixValid, pixReady;
  pix_kind_t pixKind;
  logic [DATA_W-1:0] pixData, linkData, lastImg, lastCsum, probe;
  logic [WORD_W-1:0] linkSync, idleW, imgC, darkC, lastMark;
  logic frameActiveFlag, rowActiveFlag;
  logic [1:0] darkFlags;
  logic [7:0] markCount, probeAt, imgAt;
  logic [15:0] rstv [9] = '{16'h4008, 16'hC001, 16'h03A6, 16'h002A, 16'h0015, 16'h0035,
    16'h0059, 16'h03A6, 16'h0000};
  int failures, checks_done;

  pixel_sync_framer i_dut (.core_clk, .reset, .spiSclk, .spiCsN, .spiMosi, .spiMiso,
    .pixValid, .pixReady, .pixKind, .pixData, .linkClk, .linkData, .linkSync,
    .frameActiveFlag, .rowActiveFlag);
  image_receiver_model i_rx (.linkClk, .reset, .linkData, .linkSync, .frameActiveFlag,
    .rowActiveFlag, .idleWord(idleW), .imgCode(imgC), .darkCode(darkC), .crcCode(10'h059),
    .probe, .aligned(), .lastImg, .lastCsum, .darkFlags, .lastMark, .markCount, .probeAt,
    .imgAt);

  // Clocks, the link one at an unrelated phase
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    linkClk = 1'b0;
    #3;
    forever #80 linkClk = ~linkClk;
  end

  // ==========================================
  // Tasks
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic end_sim();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic timeout();
    failures++;
    $display("mismatch at %0t: wait ran out, got %h expected %h", $time, 1'b0, 1'b1);
    end_sim();
  endtask
  task automatic check(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Serial frame: address, write bit, data; phases of 6 core cycles keep the sync happy
  task automatic spi(input logic [8:0] a, input logic w, input logic [15:0] d,
                     output logic [15:0] r);
    logic [25:0] f;
    f = {a, w, d};
    r = 16'h0000;
    spiCsN = 1'b0;
    for (int i = 25; i >= 0; i--) begin
      spiMosi = f[i];
      tick(6);
      if (i < 16) r[i] = spiMiso;
      spiSclk = 1'b1;
      tick(6);
      spiSclk = 1'b0;
    end
    tick(6);
    spiCsN = 1'b1;
    tick(6);
  endtask
  task automatic wr(input logic [8:0] a, input logic [15:0] d);
    logic [15:0] v;
    spi(a, 1'b1, d, v);
  endtask
  task automatic rdchk(input logic [8:0] a, input logic [15:0] e);
    logic [15:0] v;
    spi(a, 1'b0, 16'h0000, v);
    check(DATA_W'(v), DATA_W'(e));
  endtask
  // Valid stays up between words so it is never dropped and raised in one step
  task automatic pix(input pix_kind_t k, input logic [DATA_W-1:0] d);
    pixValid = 1'b1;
    pixKind = k;
    pixData = d;
    for (int i = 0; i < 400 && pixReady !== 1'b1; i++) tick(1);
    if (pixReady !== 1'b1) timeout();
    tick(1);
  endtask
  // One frame, an optional dark row, one image row; waits for the frame end marker
  task automatic frame(input logic [DATA_W-1:0] dk, input logic [DATA_W-1:0] im);
    logic [7:0] m;
    m = markCount + ((dk !== '0) ? 8'h06 : 8'h04);
    pix(K_FRAME_START, '0);
    if (dk !== '0) begin
      pix(K_ROW_START, '0);
      pix(K_DARK, dk);
      pix(K_ROW_END, '0);
    end
    pix(K_ROW_START, '0);
    pix(K_IMAGE, im);
    pix(K_ROW_END, '0);
    pix(K_FRAME_END, '0);
    pixValid = 1'b0;
    for (int i = 0; i < 2000 && markCount !== m; i++) tick(1);
    if (markCount !== m) timeout();
  endtask

  // ==========================================
  // Main sequence
  initial begin
    reset = 1'b1;
    {spiSclk, spiMosi, pixValid} = 3'b000;
    spiCsN = 1'b1;
    pixKind = K_FRAME_START;
    pixData = '0;
    probe = '1;
    {idleW, imgC, darkC} = {10'h3A6, 10'h035, 10'h015};
    failures = 0;
    checks_done = 0;
    // Short reset; the design stretches it for the link side
    tick(3);
    reset = 1'b0;
    tick(4);
    for (int i = 0; i < 9; i++) rdchk(9'h080 + 9'(i), rstv[i]);
    wr(9'h088, 16'hFFFF);
    wr(9'h089, 16'hFFFF);
    rdchk(9'h088, 16'h0000);
    rdchk(9'h089, 16'h0000);
    $display("test register reset values done");
    // Own codes, manual offset added, converter exponent 5, zero seed
    wr(9'h082, 16'h02B1);
    wr(9'h083, 16'h0011);
    wr(9'h084, 16'h004C);
    wr(9'h085, 16'h007E);
    {idleW, imgC, darkC} = {10'h2B1, 10'h07E, 10'h04C};
    wr(9'h080, 16'h2808);
    wr(9'h081, 16'hC0C8);
    rdchk(9'h085, 16'h007E);
    frame('0, {10'h123, 10'h200, 10'h010, 10'h3F0});
    check(lastImg, {10'h167, 10'h244, 10'h054, 10'h3FF});
    check(lastCsum, {10'h167, 10'h244, 10'h054, 10'h3FF});
    check(DATA_W'(lastMark), DATA_W'(10'h291));
    for (int i = 0; i < 400 && linkData !== {NUM_CH{10'h2B1}}; i++) tick(1);
    check(linkData, {NUM_CH{10'h2B1}});
    // Subtracted offset, all-ones seed
    wr(9'h080, 16'hA808);
    wr(9'h081, 16'hC4C8);
    frame('0, {10'h123, 10'h200, 10'h010, 10'h3F0});
    check(lastImg, {10'h09F, 10'h17C, 10'h000, 10'h36C});
    check(lastCsum, {10'h360, 10'h283, 10'h3FF, 10'h093});
    $display("test manual correction done");
    // Auto level from one dark sample, dark-row flags gated
    wr(9'h080, 16'h0008);
    wr(9'h081, 16'h0001);
    frame({NUM_CH{10'h040}}, {NUM_CH{10'h100}});
    frame({NUM_CH{10'h040}}, {NUM_CH{10'h100}});
    check(lastImg, {NUM_CH{10'h0C8}});
    check(DATA_W'(darkFlags), DATA_W'(2'b00));
    rdchk(9'h089, 16'h0000);
    // Four samples wanted but one given, flags on again
    wr(9'h080, 16'h0208);
    wr(9'h081, 16'hC001);
    frame({NUM_CH{10'h040}}, {NUM_CH{10'h100}});
    check(DATA_W'(darkFlags), DATA_W'(2'b11));
    rdchk(9'h089, 16'h000F);
    $display("test auto correction done");
    // Narrow words: sync tag trails its data by four words
    // All-ones seed, so the checksum word can never look like the probe
    wr(9'h080, 16'hA808);
    wr(9'h081, 16'hE0C8);
    probe = {10'h059, 10'h091, 10'h015, 10'h0FF};
    frame('0, {10'h123, 10'h200, 10'h010, 10'h3F0});
    check(DATA_W'(8'(imgAt - probeAt)), DATA_W'(8'h04));
    $display("test narrow mode done");
    end_sim();
  end
endmodule
`default_nettype wire
